// [pkg/eolpr_regs.svh]
// timing counts and field constants for the post-relax evaluator
// assumes a 250 MHz system clock
`ifndef EOLPR_REGS_SVH
`define EOLPR_REGS_SVH
`define EOLPR_CLK_HZ 250000000
`define EOLPR_TICK_S 1
`define EOLPR_CYC_PER_TICK (`EOLPR_CLK_HZ * `EOLPR_TICK_S)
`define EOLPR_WINDOW_S 100
`define EOLPR_RELAX_UV 4
`define EOLPR_TEMP_SPAN_DC 100
`define EOLPR_DROP_PCT 2
`define EOLPR_PCT_BASE 100
`endif

// [pkg/eolpr_pkg.sv]
// types for the post-relax evaluator
// assumes eolpr_regs.svh is available on the include path
package eolpr_pkg;
	typedef enum logic [2:0] {
		EOLPR_IDLE,
		EOLPR_RELAX,
		EOLPR_RESTORE_DSG,
		EOLPR_RESTORE_CHG,
		EOLPR_RETRY,
		EOLPR_DONE
	} eolpr_phase_t;

	typedef struct packed {
		logic relax_phase_flag;
		logic cell_rested_bit;
		logic unexpected_current_flag;
		logic learn_discharge_flag;
		logic restore_active_flag;
		logic learn_complete_flag;
		logic learn_charge_flag;
		logic charge_timeout_flag;
		logic learn_fault_flag;
		logic new_resistance_flag;
		logic temperature_abort_flag;
		logic resistance_drop_flag;
	} eolpr_flags_t;

	typedef struct packed {
		logic direct_resistance_alert;
		logic direct_resistance_warning;
	} eolpr_eos_t;
endpackage : eolpr_pkg

// [verilog/eolpr_evaluator.sv]
// post-relax sequencer, restore phases and direct-resistance decision
// assumes all inputs are synchronous to clk and resistance arrives raw, normalised here to the target temperature
`timescale 1ns/1ns
`include "eolpr_regs.svh"

// Overview of operation
// [RL1] - end of learn discharge drops load, enters post-relax, sets relax flag, 100 s windows
// [RL2] - relaxed when two consecutive window averages differ under 4 uV
// [RL3] - relax flag stays set when a fault ends post-relax
// [RL4] - unexpected current in post-relax sets its flag and aborts learning
// [RL5] - unexpected current flag clears on charge termination or status read
// [RL6] - charge-first restore discharges with load until voltage at or below charging voltage
// [RL7] - discharge-first without restore completes learning after post-relax
// [RL8] - discharge-first with restore requests host charge with charge and restore flags
// [RL9] - restore charge over time limit sets timeout and fault, charge flag kept
// [RL10] - restore fault sets fault flag, new learn starts after retry delay
// [RL11] - new resistance flag set when an estimate is stored
// [RL12] - estimate normalised to target temperature by coefficients, zero means none
// [RL13] - temperature swing over 10 C stops phase with abort and fault flags
// [RL14] - alert and warning conditions compare ratio against one plus level over 100
// [RL15] - status read clears alert bits, peek returns them unchanged
// [RL16] - drop flag set when estimate falls over 2 percent below previous
// [RL17] - alert set after alert count consecutive positives, zero count disables
// [RL18] - warning set after warning count consecutive positives, zero count disables
// [RL19] - after first condition use alert-warn interval unless it is zero
// [RL20] - after alert fires revert to normal learn interval
// [RL21] - alert clears on read, warning only on warning clear command
// [RL22] - fault flag clears when a new learning process starts
// [RL23] - one second ticks come from a prescaler on the system clock
module eolpr_evaluator
	import eolpr_pkg::*;
#(
	parameter int unsigned CYC_PER_TICK = `EOLPR_CYC_PER_TICK,
	parameter int unsigned VW = 24,
	parameter int unsigned RW = 16,
	parameter int unsigned TW = 12,
	parameter int unsigned CW = 8
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// learn sequence control
	input wire logic learn_discharge_done,
	input wire logic learn_start,
	input wire logic charge_first_mode,
	input wire logic voltage_restore_enable,
	input wire logic charge_terminated,
	input wire logic [15:0] learn_charge_time_limit_s,
	input wire logic [15:0] auto_learn_retry_s,
	// measurements, voltage in uV, temperature in 0.1 C
	input wire logic [VW-1:0] cell_voltage_uv,
	input wire logic [VW-1:0] charging_voltage_uv,
	input wire logic signed [TW-1:0] temperature_dc,
	input wire logic signed [TW-1:0] learn_target_temp_dc,
	input wire logic discharge_over_threshold,
	input wire logic charge_over_threshold,
	// resistance
	input wire logic resistance_valid,
	input wire logic [RW-1:0] raw_resistance,
	input wire logic signed [RW-1:0] temp_coeff_high,
	input wire logic signed [RW-1:0] temp_coeff_low,
	input wire logic [RW-1:0] initial_resistance,
	input wire logic [7:0] alert_level_pct,
	input wire logic [7:0] warning_level_pct,
	input wire logic [CW-1:0] alert_count_cfg,
	input wire logic [CW-1:0] warning_count_cfg,
	input wire logic [15:0] auto_learn_interval_s,
	input wire logic [15:0] alert_warn_interval_s,
	// host access
	input wire logic end_of_service_status_read,
	input wire logic end_of_service_status_peek,
	input wire logic warning_clear_command,
	// outputs
	output eolpr_flags_t flags,
	output eolpr_eos_t eos_status,
	output logic eos_status_valid,
	output logic learn_load_enable,
	output logic [RW-1:0] cell_resistance_estimate,
	output logic [15:0] learn_interval_s,
	output logic relearn_request
);
	localparam int unsigned DIVW = $clog2(CYC_PER_TICK + 1);

	typedef struct packed {
		eolpr_phase_t phase;
		eolpr_flags_t fl;
		eolpr_eos_t eos;
		logic eos_valid;
		logic load;
		logic [DIVW-1:0] div;
		logic [15:0] sec;
		logic [6:0] win;
		logic [VW+6:0] acc;
		logic [VW-1:0] prev_avg;
		logic have_prev;
		logic signed [TW-1:0] tmin;
		logic signed [TW-1:0] tmax;
		logic [RW-1:0] res;
		logic have_res;
		logic [CW-1:0] acnt;
		logic [CW-1:0] wcnt;
		logic seen_cond;
		logic [15:0] interval;
		logic relearn;
	} eolpr_state_t;

	eolpr_state_t s_q, s_d;
	// true when r exceeds initial * (1 + level/100)
	function automatic logic over_level(input logic [RW-1:0] r, input logic [RW-1:0] r0, input logic [7:0] lvl);
		logic [RW+7:0] lhs;
		logic [RW+8:0] rhs;
		lhs = (RW+8)'(r) * (RW+8)'(`EOLPR_PCT_BASE);
		rhs = (RW+9)'(r0) * (RW+9)'(`EOLPR_PCT_BASE + lvl);
		return (RW+9)'(lhs) > rhs;
	endfunction : over_level

	// temperature normalisation toward target, coefficient in 1/65536 per 0.1 C
	function automatic logic [RW-1:0] normalise(input logic [RW-1:0] r, input logic signed [TW-1:0] t,
		input logic signed [TW-1:0] tt, input logic signed [RW-1:0] kh, input logic signed [RW-1:0] kl);
		logic signed [TW:0] dt;
		logic signed [RW+TW+RW+2:0] corr;
		logic signed [RW+2:0] val;
		dt = (TW+1)'(t) - (TW+1)'(tt);
		corr = $signed({1'b0, r}) * $signed(dt >= 0 ? kh : kl) * dt;
		val = $signed({3'b000, r}) - (RW+3)'(corr >>> 16);
		if (val < 0)
			return '0;
		return val[RW-1:0];
	endfunction : normalise

	logic tick;
	logic [VW-1:0] avg_now;
	logic [VW-1:0] avg_diff;
	logic signed [TW:0] tspan;
	logic [RW-1:0] rnew;
	logic acond;
	logic wcond;
	logic fault_ev;

	always_comb
	begin
		s_d = s_q;
		tick = s_q.div == DIVW'(CYC_PER_TICK - 1);
		avg_now = VW'((s_q.acc + (VW+7)'(cell_voltage_uv)) / `EOLPR_WINDOW_S);
		avg_diff = avg_now > s_q.prev_avg ? avg_now - s_q.prev_avg : s_q.prev_avg - avg_now;
		tspan = (TW+1)'(s_q.tmax) - (TW+1)'(s_q.tmin);
		rnew = normalise(raw_resistance, temperature_dc, learn_target_temp_dc, temp_coeff_high, temp_coeff_low); // [RL12]
		acond = over_level(rnew, initial_resistance, alert_level_pct); // [RL14]
		wcond = over_level(rnew, initial_resistance, warning_level_pct); // [RL14]
		fault_ev = 1'b0;
		s_d.relearn = 1'b0;
		s_d.eos_valid = 1'b0;

		// ==================================================
		// second tick prescaler
		s_d.div = tick ? '0 : s_q.div + DIVW'(1); // [RL23]

		// ==================================================
		// sequencer
		if (s_q.phase != EOLPR_IDLE && s_q.phase != EOLPR_DONE && s_q.phase != EOLPR_RETRY)
		begin
			if (temperature_dc < s_q.tmin)
				s_d.tmin = temperature_dc;
			if (temperature_dc > s_q.tmax)
				s_d.tmax = temperature_dc;
			if (tspan > (TW+1)'(`EOLPR_TEMP_SPAN_DC))
			begin
				s_d.fl.temperature_abort_flag = 1'b1; // [RL13]
				fault_ev = 1'b1;
			end
		end
		unique case (s_q.phase)
			EOLPR_IDLE, EOLPR_DONE:
			begin
				if (learn_discharge_done)
				begin
					s_d.phase = EOLPR_RELAX; // [RL1]
					s_d.load = 1'b0; // [RL1]
					s_d.fl.relax_phase_flag = 1'b1; // [RL1]
					s_d.fl.learn_discharge_flag = 1'b0;
					s_d.fl.cell_rested_bit = 1'b0;
					s_d.win = '0;
					s_d.acc = '0;
					s_d.have_prev = 1'b0;
					s_d.tmin = temperature_dc;
					s_d.tmax = temperature_dc;
				end
			end
			EOLPR_RELAX:
			begin
				if (discharge_over_threshold || charge_over_threshold)
				begin
					s_d.fl.unexpected_current_flag = 1'b1; // [RL4]
					fault_ev = 1'b1; // [RL4]
				end
				else if (tick)
				begin
					s_d.acc = s_q.acc + (VW+7)'(cell_voltage_uv);
					s_d.win = s_q.win + 7'd1;
					if (s_q.win == 7'(`EOLPR_WINDOW_S - 1))
					begin
						s_d.win = '0;
						s_d.acc = '0;
						s_d.prev_avg = avg_now;
						s_d.have_prev = 1'b1;
						if (s_q.have_prev && avg_diff < VW'(`EOLPR_RELAX_UV)) // [RL2]
						begin
							s_d.fl.cell_rested_bit = 1'b1;
							s_d.fl.relax_phase_flag = 1'b0;
							s_d.sec = '0;
							if (charge_first_mode)
							begin
								if (voltage_restore_enable && cell_voltage_uv > charging_voltage_uv)
								begin
									s_d.phase = EOLPR_RESTORE_DSG; // [RL6]
									s_d.fl.learn_discharge_flag = 1'b1; // [RL6]
									s_d.fl.restore_active_flag = 1'b1; // [RL6]
									s_d.load = 1'b1; // [RL6]
								end
								else
								begin
									s_d.phase = EOLPR_DONE;
									s_d.fl.learn_complete_flag = 1'b1;
								end
							end
							else if (voltage_restore_enable)
							begin
								s_d.phase = EOLPR_RESTORE_CHG; // [RL8]
								s_d.fl.learn_charge_flag = 1'b1; // [RL8]
								s_d.fl.restore_active_flag = 1'b1; // [RL8]
							end
							else
							begin
								s_d.phase = EOLPR_DONE; // [RL7]
								s_d.fl.learn_complete_flag = 1'b1; // [RL7]
							end
						end
					end
				end
			end
			EOLPR_RESTORE_DSG:
			begin
				if (cell_voltage_uv <= charging_voltage_uv)
				begin
					s_d.load = 1'b0; // [RL6]
					s_d.fl.learn_discharge_flag = 1'b0; // [RL6]
					s_d.fl.restore_active_flag = 1'b0;
					s_d.fl.learn_complete_flag = 1'b1;
					s_d.phase = EOLPR_DONE;
				end
			end
			EOLPR_RESTORE_CHG:
			begin
				if (charge_terminated)
				begin
					s_d.fl.learn_charge_flag = 1'b0;
					s_d.fl.restore_active_flag = 1'b0;
					s_d.fl.learn_complete_flag = 1'b1;
					s_d.phase = EOLPR_DONE;
				end
				else if (tick)
				begin
					s_d.sec = s_q.sec + 16'd1;
					if (s_q.sec + 16'd1 >= learn_charge_time_limit_s)
					begin
						s_d.fl.charge_timeout_flag = 1'b1; // [RL9]
						fault_ev = 1'b1; // [RL9]
					end
				end
			end
			EOLPR_RETRY:
			begin
				if (tick)
				begin
					s_d.sec = s_q.sec + 16'd1;
					if (s_q.sec + 16'd1 >= auto_learn_retry_s)
					begin
						s_d.relearn = 1'b1; // [RL10]
						s_d.phase = EOLPR_IDLE;
					end
				end
			end
		endcase

		// fault leaves phase flags standing for the host
		if (fault_ev)
		begin
			s_d.fl.learn_fault_flag = 1'b1; // [RL3] [RL9] [RL10] [RL13]
			s_d.load = 1'b0;
			s_d.sec = '0;
			s_d.phase = EOLPR_RETRY; // [RL10]
		end

		if (learn_start && !fault_ev)
		begin
			s_d.fl.learn_fault_flag = 1'b0; // [RL22]
			s_d.fl.learn_complete_flag = 1'b0;
			s_d.fl.relax_phase_flag = 1'b0;
			s_d.fl.learn_charge_flag = 1'b0;
			s_d.fl.charge_timeout_flag = 1'b0;
			s_d.fl.temperature_abort_flag = 1'b0;
			s_d.fl.restore_active_flag = 1'b0;
			s_d.fl.new_resistance_flag = 1'b0;
			s_d.fl.resistance_drop_flag = 1'b0;
		end

		// set wins over clear for the unexpected current flag
		if ((charge_terminated || end_of_service_status_read) && !fault_ev)
			s_d.fl.unexpected_current_flag = 1'b0; // [RL5]

		// ==================================================
		// direct resistance decision
		if (end_of_service_status_read || end_of_service_status_peek)
		begin
			s_d.eos_valid = 1'b1; // [RL15]
			if (end_of_service_status_read)
				s_d.eos.direct_resistance_alert = 1'b0; // [RL15] [RL21]
		end
		if (warning_clear_command)
			s_d.eos.direct_resistance_warning = 1'b0; // [RL21]
		if (resistance_valid)
		begin
			s_d.res = rnew;
			s_d.have_res = 1'b1;
			s_d.fl.new_resistance_flag = 1'b1; // [RL11]
			if (s_q.have_res && (RW+7)'(rnew) * (RW+7)'(`EOLPR_PCT_BASE) <
				(RW+7)'(s_q.res) * (RW+7)'(`EOLPR_PCT_BASE - `EOLPR_DROP_PCT))
				s_d.fl.resistance_drop_flag = 1'b1; // [RL16]
			s_d.acnt = (acond && alert_count_cfg != '0) ? s_q.acnt + CW'(1) : '0;
			s_d.wcnt = (wcond && warning_count_cfg != '0) ? s_q.wcnt + CW'(1) : '0;
			if (acond || wcond)
				s_d.seen_cond = 1'b1;
			if ((acond || wcond) && alert_warn_interval_s != 16'h0000)
				s_d.interval = alert_warn_interval_s; // [RL19]
			else if (!s_q.seen_cond && !acond && !wcond)
				s_d.interval = auto_learn_interval_s;
			if (acond && alert_count_cfg != '0 && s_q.acnt + CW'(1) >= alert_count_cfg)
			begin
				s_d.eos.direct_resistance_alert = 1'b1; // [RL17]
				s_d.acnt = '0;
				s_d.interval = auto_learn_interval_s; // [RL20]
			end
			if (wcond && warning_count_cfg != '0 && s_q.wcnt + CW'(1) >= warning_count_cfg)
			begin
				s_d.eos.direct_resistance_warning = 1'b1; // [RL18]
				s_d.wcnt = warning_count_cfg;
			end
		end
		if (s_q.interval == 16'h0000)
			s_d.interval = auto_learn_interval_s; // [RL19]
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	// ==================================================
	// outputs
	assign flags = s_q.fl;
	assign eos_status = s_q.eos;
	assign eos_status_valid = s_q.eos_valid;
	assign learn_load_enable = s_q.load;
	assign cell_resistance_estimate = s_q.res;
	assign learn_interval_s = s_q.interval;
	assign relearn_request = s_q.relearn;
endmodule : eolpr_evaluator

// [verification/eolpr_evaluator_asserts.sv]
// concurrent checks on the post-relax evaluator
// assumes binding to eolpr_evaluator, sees its ports only
`timescale 1ns/1ns
module eolpr_evaluator_asserts
	import eolpr_pkg::*;
#(
	parameter int unsigned VW = 24
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// device inputs
	input wire logic learn_discharge_done,
	input wire logic learn_start,
	input wire logic discharge_over_threshold,
	input wire logic charge_over_threshold,
	input wire logic [VW-1:0] cell_voltage_uv,
	input wire logic [VW-1:0] charging_voltage_uv,
	input wire logic resistance_valid,
	input wire logic end_of_service_status_read,
	input wire logic end_of_service_status_peek,
	input wire logic warning_clear_command,
	// device outputs
	input wire eolpr_flags_t flags,
	input wire eolpr_eos_t eos_status,
	input wire logic eos_status_valid,
	input wire logic learn_load_enable,
	input wire logic relearn_request
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// a fault leaves the sequencer waiting out the retry delay
	logic retry_pend_q;
	always_ff @(posedge clk)
	begin
		if (rst || relearn_request)
			retry_pend_q <= 1'b0;
		else if ($rose(flags.learn_fault_flag))
			retry_pend_q <= 1'b1;
	end
	// ==========================================
	// sequencing
	AST_RELAX_START: assert property (learn_discharge_done && !flags.relax_phase_flag
		&& !flags.learn_fault_flag && !flags.learn_charge_flag && !flags.restore_active_flag
		&& !flags.learn_discharge_flag && !retry_pend_q
		|=> flags.relax_phase_flag && !learn_load_enable) else $error("post-relax not entered");
	AST_UCD_SET: assert property (flags.relax_phase_flag && !flags.cell_rested_bit && !learn_start
		&& !flags.unexpected_current_flag && !flags.learn_fault_flag && !flags.temperature_abort_flag
		&& (discharge_over_threshold || charge_over_threshold)
		|=> flags.unexpected_current_flag) else $error("unexpected current missed");
	AST_RELAX_KEEP: assert property (flags.unexpected_current_flag && flags.relax_phase_flag
		&& !learn_start |=> flags.relax_phase_flag) else $error("relax flag lost on fault");
	AST_UCD_CLR: assert property (flags.unexpected_current_flag && end_of_service_status_read
		&& !discharge_over_threshold && !charge_over_threshold
		|=> !flags.unexpected_current_flag) else $error("unexpected current not cleared");
	AST_LOAD_OFF: assert property (learn_load_enable && flags.restore_active_flag
		&& cell_voltage_uv <= charging_voltage_uv
		|=> ##[0:2] !learn_load_enable && !flags.learn_discharge_flag) else $error("restore load kept");
	// ==========================================
	// status access
	AST_READ_CLR: assert property (end_of_service_status_read && !resistance_valid
		|=> eos_status_valid && !eos_status.direct_resistance_alert) else $error("alert not cleared");
	AST_PEEK: assert property (end_of_service_status_peek && !end_of_service_status_read
		&& !resistance_valid && !warning_clear_command
		|=> eos_status_valid && $stable(eos_status)) else $error("peek changed status");
	AST_WARN_KEEP: assert property (eos_status.direct_resistance_warning && !warning_clear_command
		|=> eos_status.direct_resistance_warning) else $error("warning dropped");
endmodule : eolpr_evaluator_asserts

// [verification/eolpr_host_model.sv]
// host model: runs the restore charger and the learning load
// assumes device flags are registered on clk
`timescale 1ns/1ns
module eolpr_host_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// never terminate charging when set
	input wire logic stall,
	// device requests
	input wire logic learn_charge_flag,
	input wire logic learn_load_enable,
	// answers to the device
	output logic charge_terminated,
	output logic [23:0] cell_voltage_uv
);
	logic [4:0] chg_q;
	assign charge_terminated = (chg_q == 5'h14);
	// load sinks one microvolt a cycle, a finished charge restores full voltage
	always_ff @(posedge clk)
	begin
		if (rst || !learn_charge_flag)
			chg_q <= 5'h00;
		else if (!stall && !charge_terminated)
			chg_q <= chg_q + 5'h01;
		if (rst || charge_terminated)
			cell_voltage_uv <= 24'h2D_C6F0;
		else if (learn_load_enable)
			cell_voltage_uv <= cell_voltage_uv - 24'h00_0001;
	end
endmodule : eolpr_host_model

// [verification/eolpr_evaluator_tb_top.sv]
// self-checking bench for the post-relax evaluator
// assumes a 10-cycle second tick so windows last 1000 cycles
`timescale 1ns/1ns
module eolpr_evaluator_tb_top
	import eolpr_pkg::*;
;
	logic clk = 0, rst = 1, stall = 0, charge_first_mode = 0, voltage_restore_enable = 0;
	logic learn_discharge_done = 0, learn_start = 0, discharge_over_threshold = 0, charge_over_threshold = 0;
	logic resistance_valid = 0, end_of_service_status_read = 0, end_of_service_status_peek = 0;
	logic warning_clear_command = 0, charge_terminated, eos_status_valid, learn_load_enable, relearn_request;
	logic [15:0] raw_resistance = 16'h0000, lim = 16'h0005, rty = 16'h0003, ival = 16'h0064, awi = 16'h0032;
	logic [15:0] ires = 16'h03E8, r1, cell_resistance_estimate, learn_interval_s;
	logic [7:0] alv = 8'h14, wlv = 8'h0A, acnt = 8'h02, wcnt = 8'h01;
	logic signed [11:0] temperature_dc = 12'sh0FA;
	logic signed [15:0] kh = 16'sh0000;
	logic [23:0] cell_voltage_uv;
	eolpr_flags_t flags;
	eolpr_eos_t eos_status;
	logic [1:0] q[$];
	int err_total = 0, n_compared = 0, cyc = 0, i, k, seed = 97335;
	eolpr_evaluator #(.CYC_PER_TICK(10)) dut_u (.clk, .rst, .learn_discharge_done, .learn_start,
		.charge_first_mode, .voltage_restore_enable, .charge_terminated, .learn_charge_time_limit_s(lim),
		.auto_learn_retry_s(rty), .cell_voltage_uv, .charging_voltage_uv(24'h2D_C6C0), .temperature_dc,
		.learn_target_temp_dc(12'sh0FA), .discharge_over_threshold, .charge_over_threshold, .resistance_valid,
		.raw_resistance, .temp_coeff_high(kh), .temp_coeff_low(16'sh0000), .initial_resistance(ires),
		.alert_level_pct(alv), .warning_level_pct(wlv), .alert_count_cfg(acnt), .warning_count_cfg(wcnt),
		.auto_learn_interval_s(ival), .alert_warn_interval_s(awi), .end_of_service_status_read,
		.end_of_service_status_peek, .warning_clear_command, .flags, .eos_status, .eos_status_valid,
		.learn_load_enable, .cell_resistance_estimate, .learn_interval_s, .relearn_request);
	eolpr_host_model host_u (.clk, .rst, .stall, .learn_charge_flag(flags.learn_charge_flag),
		.learn_load_enable, .charge_terminated, .cell_voltage_uv);
	task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wrap_up;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// wait for one flag bit to reach a level, bounded
	task wt(input int b, input logic v, input int n);
		for (i = 0; i < n && flags[b] !== v; i++)
			@(negedge clk);
	endtask : wt
	// wait for the retry delay to end in a relearn request, bounded
	task wrl;
		for (i = 0; i < 100 && relearn_request !== 1'b1; i++)
			@(negedge clk);
	endtask : wrl
	task learn(input logic cf, input logic vr);
		charge_first_mode = cf;
		voltage_restore_enable = vr;
		learn_start = 1;
		@(negedge clk);
		learn_start = 0;
		@(negedge clk);
		learn_discharge_done = 1;
		@(negedge clk);
		learn_discharge_done = 0;
	endtask : learn
	// host access: {read, peek, warning clear}, expected status noted for the monitor
	task hop(input logic [2:0] o, input logic [1:0] e);
		{end_of_service_status_read, end_of_service_status_peek, warning_clear_command} = o;
		if (o[2:1] != 2'b00)
			q.push_back(e);
		@(negedge clk);
		{end_of_service_status_read, end_of_service_status_peek, warning_clear_command} = 3'b000;
		repeat (2) @(negedge clk);
	endtask : hop
	task rv;
		resistance_valid = 1;
		@(negedge clk);
		resistance_valid = 0;
		repeat (3) @(negedge clk);
	endtask : rv
	initial
	begin
		forever #2 clk = ~clk;
	end
	always @(negedge clk)
	begin
		cyc++;
		if (eos_status_valid === 1'b1)
			chk("eos", q.size() != 0 ? q.pop_front() : 24'hFF_FFFF, eos_status);
		if (cyc == 30000)
		begin
			err_total++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (16) @(negedge clk);
		rst = 0;
		learn(0, 0);
		chk("relax", 1'b1, flags.relax_phase_flag);
		chk("load", 1'b0, learn_load_enable);
		wt(10, 1, 5000);
		chk("twowin", 1'b1, flags.cell_rested_bit && i >= 1980 && i <= 2010);
		wt(6, 1, 10);
		chk("done", 1'b1, flags.learn_complete_flag);
		learn(1, 1);
		wt(8, 1, 5000);
		chk("rstor", 1'b1, flags.restore_active_flag & learn_load_enable & flags.learn_discharge_flag);
		wt(8, 0, 200);
		chk("vfloor", 1'b1, cell_voltage_uv <= 24'h2D_C6C0 && !learn_load_enable && !flags.learn_discharge_flag);
		learn(1, 0);
		wt(6, 1, 5000);
		chk("cfdone", 2'b10, {flags.learn_complete_flag, flags.restore_active_flag});
		learn(0, 1);
		wt(5, 1, 5000);
		chk("chgreq", 1'b1, flags.restore_active_flag);
		wt(5, 0, 100);
		chk("nofault", 1'b0, flags.learn_fault_flag);
		stall = 1;
		learn(0, 1);
		wt(4, 1, 5000);
		chk("tofault", 3'b111, {flags.charge_timeout_flag, flags.learn_fault_flag, flags.learn_charge_flag});
		wrl();
		chk("retry", 1'b1, relearn_request && i >= 25 && i <= 30);
		stall = 0;
		for (k = 0; k < 3; k++)
		begin
			learn(0, 0);
			chk("fclr", 1'b0, flags.learn_fault_flag);
			repeat (50) @(negedge clk);
			discharge_over_threshold = (k == 0);
			charge_over_threshold = (k == 1);
			temperature_dc = (k == 2) ? 12'sh15F : 12'sh0FA;
			@(negedge clk);
			{discharge_over_threshold, charge_over_threshold} = 2'b00;
			repeat (3) @(negedge clk);
			chk("ucd", k < 2, flags.unexpected_current_flag);
			chk("tabort", k == 2, flags.temperature_abort_flag);
			chk("relaxkeep", 1'b1, flags.relax_phase_flag);
			temperature_dc = 12'sh0FA;
			hop(3'b100, 2'b00);
			chk("ucdclr", 1'b0, flags.unexpected_current_flag);
			wrl();
			chk("relearn", 1'b1, relearn_request);
		end
		r1 = 16'h0514 + 16'($random(seed) & 16'h00FF);
		raw_resistance = r1;
		rv();
		chk("new_resistance_flag", 1'b1, flags.new_resistance_flag);
		chk("rcell", r1, cell_resistance_estimate);
		chk("ival", awi, learn_interval_s);
		hop(3'b010, 2'b01);
		rv();
		hop(3'b010, 2'b11);
		chk("ival", ival, learn_interval_s);
		hop(3'b100, 2'b01);
		hop(3'b010, 2'b01);
		hop(3'b001, 2'b00);
		hop(3'b010, 2'b00);
		raw_resistance = r1 - (r1 >> 4);
		rv();
		chk("drop", 1'b1, flags.resistance_drop_flag);
		// 1.0 C above target with a high coefficient of 256/65536 per 0.1 C
		kh = 16'sh0100;
		temperature_dc = 12'sh104;
		raw_resistance = r1;
		rv();
		chk("norm", r1 - 16'((32'(r1) * 32'd2560) >> 16), cell_resistance_estimate);
		wrap_up();
	end
endmodule : eolpr_evaluator_tb_top
bind eolpr_evaluator eolpr_evaluator_asserts #(.VW(VW)) chk_u (.clk, .rst, .learn_discharge_done, .learn_start,
	.discharge_over_threshold, .charge_over_threshold, .cell_voltage_uv, .charging_voltage_uv, .resistance_valid,
	.end_of_service_status_read, .end_of_service_status_peek, .warning_clear_command, .flags, .eos_status,
	.eos_status_valid, .learn_load_enable, .relearn_request);
